// [hw/isr_cond_set.sv]
`timescale 1ns/10ps
`include "isr_defines.svh"
module isr_cond_set (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [`ISR_SET_W-1:0] live,
  output logic [`ISR_SET_W-1:0] cond,
  output logic [`ISR_SET_W-1:0] rise
);
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cond <= '0;
    end else begin
      cond <= live; // (R3) (R7)
    end
  end
  assign rise = live & ~cond; // (R4)
endmodule

// [hw/isr_defines.svh]
// Summary of operation
// (R1) status sets sixteen bits, byte sets eight
// (R2) each set has event and enable registers
// (R3) condition registers follow live inputs, always readable
// (R4) only rising condition edges set event bits
// (R5) reading an event register clears it
// (R6) clear-status command clears all event registers
// (R7) condition bit drops only when condition ends
// (R8) enable bits mask events from each summary
// (R9) overvoltage fault drives questionable condition bit 0
// (R10) enabled questionable event sets summary bit 3
// (R11) enabled summary bit sets bit 6, service request
// (R12) bit 6 is never masked by enable
// (R13) bit 0 zero, bit 1 list running
// (R14) bit 2 set while error queue not empty
// (R15) bit 4 set while response message waits
// (R16) bit 5 set by enabled standard event
// (R17) bit 7 set by enabled operation event
// (R18) good command yields no error, bit 3 zero
// (R19) host reads summary then queries pointed set
// (R20) operation condition bits 5, 8, 10, 14
// (R21) standard event bits 0,2,3,4,5,7 only
// (R22) service request drops when no enabled summary
`ifndef ISR_DEFINES_SVH
`define ISR_DEFINES_SVH
`define ISR_SET_W 16
`define ISR_STD_W 8
`define ISR_SB_LIST 1
`define ISR_SB_ERRQ 2
`define ISR_SB_QUES 3
`define ISR_SB_MAV 4
`define ISR_SB_ESB 5
`define ISR_SB_RQS 6
`define ISR_SB_OPER 7
`define ISR_OP_WTRIG 5
`define ISR_OP_CV 8
`define ISR_OP_CC 10
`define ISR_OP_PROG 14
`define ISR_QU_OV 0
`define ISR_QU_OC 1
`define ISR_QU_LEAD 2
`define ISR_QU_OT 3
`define ISR_QU_PWR 4
`define ISR_QU_FAN 5
`define ISR_QU_LINK 6
`define ISR_QU_USED 7
`define ISR_STD_MASK 8'hbd
`endif

// [hw/isr_event_set.sv]
`timescale 1ns/10ps
`include "isr_defines.svh"
module isr_event_set #(
  parameter int W = 16
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [W-1:0] set_bits,
  input wire logic clear,
  input wire logic [W-1:0] enable,
  output logic [W-1:0] event_bits,
  output logic summary
);
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
          event_bits[i] <= 1'b0;
        end else if (set_bits[i]) begin
          // set wins over a same-cycle read clear
          event_bits[i] <= 1'b1;
        end else if (clear) begin
          event_bits[i] <= 1'b0; // (R5) (R6)
        end
      end
    end
  endgenerate
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      summary <= 1'b0;
    end else begin
      summary <= |((event_bits | set_bits) & enable &
        ~({W{clear}} & ~set_bits)); // (R8)
    end
  end
endmodule

// [hw/isr_pkg.sv]
package isr_pkg;
  typedef enum logic [2:0] {
    ISR_SEL_QUES = 3'b000,
    ISR_SEL_OPER = 3'b001,
    ISR_SEL_STD = 3'b010,
    ISR_SEL_SUMMARY = 3'b011,
    ISR_SEL_QCOND = 3'b100,
    ISR_SEL_OCOND = 3'b101
  } isr_sel_t;
endpackage

// [hw/isr_top.sv]
`timescale 1ns/10ps
`include "isr_defines.svh"
module isr_top (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic overvoltage,
  input wire logic overcurrent,
  input wire logic lead_error,
  input wire logic overtemp,
  input wire logic input_power_error,
  input wire logic fan_error,
  input wire logic link_error,
  input wire logic waiting_trigger,
  input wire logic const_voltage,
  input wire logic const_current,
  input wire logic program_running,
  input wire logic list_running,
  input wire logic error_queue_nonempty,
  input wire logic message_available,
  input wire logic [`ISR_STD_W-1:0] std_event_in,
  input wire logic clear_status,
  input wire logic rd_stb,
  input wire isr_pkg::isr_sel_t rd_sel,
  input wire logic wr_stb,
  input wire isr_pkg::isr_sel_t wr_sel,
  input wire logic [`ISR_SET_W-1:0] wr_data,
  output logic [`ISR_SET_W-1:0] rd_data,
  output logic [`ISR_STD_W-1:0] status_summary_byte,
  output logic srq
);
  logic [`ISR_SET_W-1:0] q_live;
  logic [`ISR_SET_W-1:0] o_live;
  logic [`ISR_SET_W-1:0] q_cond;
  logic [`ISR_SET_W-1:0] o_cond;
  logic [`ISR_SET_W-1:0] q_rise;
  logic [`ISR_SET_W-1:0] o_rise;
  logic [`ISR_SET_W-1:0] q_event;
  logic [`ISR_SET_W-1:0] o_event;
  logic [`ISR_SET_W-1:0] q_enable;
  logic [`ISR_SET_W-1:0] o_enable;
  logic [`ISR_STD_W-1:0] standard_event_register;
  logic [`ISR_STD_W-1:0] standard_event_enable;
  logic [`ISR_STD_W-1:0] service_request_enable_mask;
  logic [`ISR_STD_W-1:0] std_set;
  logic q_sum;
  logic o_sum;
  logic s_sum;
  logic q_clr;
  logic o_clr;
  logic s_clr;
  logic [`ISR_STD_W-1:0] next_summary;
  logic request_for_service_flag;

  // unused questionable bits tie low; bit 0 is overvoltage
  always_comb begin
    q_live = '0;
    q_live[`ISR_QU_OV] = overvoltage; // (R9)
    q_live[`ISR_QU_OC] = overcurrent;
    q_live[`ISR_QU_LEAD] = lead_error;
    q_live[`ISR_QU_OT] = overtemp;
    q_live[`ISR_QU_PWR] = input_power_error;
    q_live[`ISR_QU_FAN] = fan_error;
    q_live[`ISR_QU_LINK] = link_error;
  end

  always_comb begin
    o_live = '0; // (R20)
    o_live[`ISR_OP_WTRIG] = waiting_trigger;
    o_live[`ISR_OP_CV] = const_voltage;
    o_live[`ISR_OP_CC] = const_current;
    o_live[`ISR_OP_PROG] = program_running;
  end

  assign std_set = std_event_in & `ISR_STD_MASK; // (R21)
  assign q_clr = clear_status |
    (rd_stb && rd_sel == isr_pkg::ISR_SEL_QUES); // (R5) (R6)
  assign o_clr = clear_status | (rd_stb && rd_sel == isr_pkg::ISR_SEL_OPER);
  assign s_clr = clear_status | (rd_stb && rd_sel == isr_pkg::ISR_SEL_STD);

  // (R1) (R2)
  isr_cond_set u_qcond (
    .mclk(mclk),
    .rst_n(rst_n),
    .live(q_live),
    .cond(q_cond),
    .rise(q_rise)
  );

  isr_cond_set u_ocond (
    .mclk(mclk),
    .rst_n(rst_n),
    .live(o_live),
    .cond(o_cond),
    .rise(o_rise)
  );

  isr_event_set #(.W(`ISR_SET_W)) u_qev (
    .mclk(mclk),
    .rst_n(rst_n),
    .set_bits(q_rise),
    .clear(q_clr),
    .enable(q_enable),
    .event_bits(q_event),
    .summary(q_sum)
  );

  isr_event_set #(.W(`ISR_SET_W)) u_oev (
    .mclk(mclk),
    .rst_n(rst_n),
    .set_bits(o_rise),
    .clear(o_clr),
    .enable(o_enable),
    .event_bits(o_event),
    .summary(o_sum)
  );

  isr_event_set #(.W(`ISR_STD_W)) u_sev (
    .mclk(mclk),
    .rst_n(rst_n),
    .set_bits(std_set),
    .clear(s_clr),
    .enable(standard_event_enable),
    .event_bits(standard_event_register),
    .summary(s_sum)
  );

  // enable registers, written by the command parser
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      q_enable <= '0;
      o_enable <= '0;
      standard_event_enable <= '0;
      service_request_enable_mask <= '0;
    end else if (wr_stb) begin
      case (wr_sel)
        isr_pkg::ISR_SEL_QUES: q_enable <= wr_data;
        isr_pkg::ISR_SEL_OPER: o_enable <= wr_data;
        isr_pkg::ISR_SEL_STD:
          standard_event_enable <= wr_data[`ISR_STD_W-1:0];
        isr_pkg::ISR_SEL_SUMMARY:
          service_request_enable_mask <= wr_data[`ISR_STD_W-1:0];
        default: ;
      endcase
    end
  end

  always_comb begin
    next_summary = '0; // (R13)
    next_summary[`ISR_SB_LIST] = list_running; // (R13)
    next_summary[`ISR_SB_ERRQ] = error_queue_nonempty; // (R14) (R18)
    next_summary[`ISR_SB_QUES] = q_sum; // (R10) (R18)
    next_summary[`ISR_SB_MAV] = message_available; // (R15)
    next_summary[`ISR_SB_ESB] = s_sum; // (R16)
    next_summary[`ISR_SB_OPER] = o_sum; // (R17)
    // mask bit 6 ignored so it cannot feed itself
    request_for_service_flag = |(next_summary &
      service_request_enable_mask &
      ~(8'h01 << `ISR_SB_RQS)); // (R11) (R12)
    next_summary[`ISR_SB_RQS] = request_for_service_flag; // (R12)
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      status_summary_byte <= '0;
      srq <= 1'b0;
    end else begin
      status_summary_byte <= next_summary;
      srq <= request_for_service_flag; // (R11) (R22)
    end
  end

  // read data one cycle after the strobe; host follows the summary (R19)
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data <= '0;
    end else if (rd_stb) begin
      case (rd_sel)
        isr_pkg::ISR_SEL_QUES: rd_data <= q_event;
        isr_pkg::ISR_SEL_OPER: rd_data <= o_event;
        isr_pkg::ISR_SEL_STD: rd_data <= {8'h00, standard_event_register};
        isr_pkg::ISR_SEL_SUMMARY: rd_data <= {8'h00, status_summary_byte};
        isr_pkg::ISR_SEL_QCOND: rd_data <= q_cond; // (R3)
        isr_pkg::ISR_SEL_OCOND: rd_data <= o_cond;
        default: rd_data <= '0;
      endcase
    end
  end
endmodule

// [tb/isr_host.sv]
`timescale 1ns/10ps
module isr_host (
  input wire logic mclk,
  input wire logic [15:0] rd_data,
  input wire logic [7:0] ssb,
  output logic rd_stb,
  output isr_pkg::isr_sel_t rd_sel,
  output logic wr_stb,
  output isr_pkg::isr_sel_t wr_sel,
  output logic [15:0] wr_data
);
  initial begin
    rd_stb = 1'b0;
    wr_stb = 1'b0;
    rd_sel = isr_pkg::ISR_SEL_QUES;
    wr_sel = isr_pkg::ISR_SEL_QUES;
    wr_data = 16'h0000;
  end
  task automatic rd(input isr_pkg::isr_sel_t s, output logic [15:0] d);
    @(negedge mclk);
    rd_stb = 1'b1;
    rd_sel = s;
    @(negedge mclk);
    rd_stb = 1'b0;
    @(negedge mclk);
    d = rd_data;
  endtask
  task automatic wr(input isr_pkg::isr_sel_t s, input logic [15:0] v);
    @(negedge mclk);
    wr_stb = 1'b1;
    wr_sel = s;
    wr_data = v;
    @(negedge mclk);
    wr_stb = 1'b0;
    wr_data = ~v; // stale data must not pass for valid
  endtask
  // only questionable and operation causes are chased
  task automatic poll(output logic [15:0] d);
    if (ssb[3]) rd(isr_pkg::ISR_SEL_QUES, d);
    else rd(isr_pkg::ISR_SEL_OPER, d);
  endtask
endmodule

// [tb/isr_top_asserts.sv]
`timescale 1ns/10ps
module isr_chk (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic list_running,
  input wire logic clear_status,
  input wire logic rd_stb,
  input wire isr_pkg::isr_sel_t rd_sel,
  input wire logic [15:0] rd_data,
  input wire logic [7:0] status_summary_byte,
  input wire logic srq
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  wire [7:0] ssb = status_summary_byte;
  a_bit0_zero: assert property (!ssb[0])
    else $error("bit0 set");
  a_list_follow: assert property (
    $rose(list_running) |-> ##[1:3] ssb[1]) else $error("list bit late");
  a_srq_bit6: assert property (srq == ssb[6])
    else $error("srq differs");
  a_srq_drop: assert property ((ssb & 8'hbf) == 8'h00 |-> !srq)
    else $error("srq stuck");
  // four edges: event and summary clear on the clear edge, the byte one edge later, so the byte is clear from the second edge on
  a_clear_events: assert property (
    clear_status |-> ##4 (ssb & 8'ha8) == 8'h00) else $error("clear missed");
  a_qcond_unused: assert property (
    rd_stb && rd_sel == isr_pkg::ISR_SEL_QCOND
    |=> rd_data[15:7] == 9'h000) else $error("qcond upper");
  a_ocond_map: assert property (
    rd_stb && rd_sel == isr_pkg::ISR_SEL_OCOND
    |=> (rd_data & 16'hbadf) == 16'h0000) else $error("ocond map");
  a_std_unused: assert property (
    rd_stb && rd_sel == isr_pkg::ISR_SEL_STD
    |=> (rd_data & 16'hff42) == 16'h0000) else $error("std bits");
  a_unmapped_zero: assert property (
    rd_stb && rd_sel > 3'h5
    |=> rd_data == 16'h0000) else $error("unmapped");
endmodule
bind isr_top isr_chk u_chk (.mclk, .rst_n, .list_running, .clear_status,
  .rd_stb, .rd_sel, .rd_data, .status_summary_byte, .srq);

// [tb/isr_top_test.sv]
`timescale 1ns/10ps
module isr_top_test;
  logic mclk, rst_n, lr, eq, ma, cs, rd_stb, wr_stb, srq;
  logic [6:0] q;
  logic [3:0] o;
  logic [7:0] se, ssb;
  logic [15:0] wr_data, rd_data, d;
  isr_pkg::isr_sel_t rd_sel, wr_sel;
  int fail_count = 0;
  int cmp_count = 0;
  isr_top DUT (.mclk(mclk), .rst_n(rst_n), .overvoltage(q[0]),
    .overcurrent(q[1]), .lead_error(q[2]), .overtemp(q[3]),
    .input_power_error(q[4]), .fan_error(q[5]), .link_error(q[6]),
    .waiting_trigger(o[0]), .const_voltage(o[1]), .const_current(o[2]),
    .program_running(o[3]), .list_running(lr), .error_queue_nonempty(eq),
    .message_available(ma), .std_event_in(se), .clear_status(cs),
    .rd_stb(rd_stb), .rd_sel(rd_sel), .wr_stb(wr_stb), .wr_sel(wr_sel),
    .wr_data(wr_data), .rd_data(rd_data), .status_summary_byte(ssb),
    .srq(srq));
  isr_host host (.mclk(mclk), .rd_data(rd_data), .ssb(ssb),
    .rd_stb(rd_stb), .rd_sel(rd_sel), .wr_stb(wr_stb), .wr_sel(wr_sel),
    .wr_data(wr_data));
  task chk(input logic ok, input string m);
    cmp_count++;
    if (ok !== 1'b1) begin
      fail_count++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask
  task print_verdict;
    if (fail_count == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task settle;
    repeat (4) @(negedge mclk);
  endtask
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  initial begin
    #100us;
    fail_count++;
    print_verdict();
  end
  initial begin
    {q, o, lr, eq, ma, se, cs} = '0;
    rst_n = 1'b0;
    void'($urandom(32'h2b3e));
    repeat (2) @(negedge mclk);
    rst_n = 1'b1;
    chk(ssb === 8'h00 && srq === 1'b0, "reset");
    repeat (24) begin
      {lr, eq, ma, q, o} = 14'($urandom);
      settle();
      chk(ssb === {3'h0, ma, 1'b0, eq, lr, 1'b0}, "lvl");
    end
    {q, o, lr, eq, ma} = '0;
    @(negedge mclk) cs = 1'b1;
    @(negedge mclk) cs = 1'b0;
    host.wr(isr_pkg::ISR_SEL_QUES, 16'h0001);
    host.wr(isr_pkg::ISR_SEL_SUMMARY, 16'h0040);
    q[0] = 1'b1;
    settle();
    chk(ssb === 8'h08 && srq === 1'b0, "mask bit6");
    host.wr(isr_pkg::ISR_SEL_SUMMARY, 16'h0008);
    settle();
    chk(ssb === 8'h48 && srq === 1'b1, "srq");
    host.rd(isr_pkg::ISR_SEL_QCOND, d);
    chk(d === 16'h0001, "qcond");
    host.poll(d);
    chk(d === 16'h0001, "ques event");
    host.rd(isr_pkg::ISR_SEL_QUES, d);
    chk(d === 16'h0000, "read clear");
    q[0] = 1'b0;
    settle();
    chk(ssb === 8'h00 && srq === 1'b0, "srq drop");
    host.rd(isr_pkg::ISR_SEL_QCOND, d);
    chk(d === 16'h0000, "qcond drop");
    host.rd(isr_pkg::ISR_SEL_QUES, d);
    chk(d === 16'h0000, "fall event");
    host.wr(isr_pkg::ISR_SEL_OPER, 16'h0100);
    o = 4'hf;
    settle();
    chk(ssb === 8'h80 && srq === 1'b0, "oper");
    host.rd(isr_pkg::ISR_SEL_OCOND, d);
    chk(d === 16'h4520, "ocond");
    host.wr(isr_pkg::ISR_SEL_STD, 16'h0082);
    se = 8'h02;
    @(negedge mclk) se = 8'h00;
    settle();
    chk(ssb === 8'h80, "std bit1");
    se = 8'h80;
    @(negedge mclk) se = 8'h00;
    settle();
    chk(ssb === 8'ha0, "std bit7");
    @(negedge mclk) cs = 1'b1;
    @(negedge mclk) cs = 1'b0;
    settle();
    chk(ssb === 8'h00, "clear");
    host.rd(isr_pkg::isr_sel_t'(3'h6), d);
    chk(d === 16'h0000, "unmapped");
    print_verdict();
  end
endmodule
